/* pkg/led_pwm_pkg.sv */
// Shared constants for the LED matrix duty controller and its host sequencer.
// Assumes a single 10 MHz clock and synchronous inputs on both ends.
package led_pwm_pkg;
  // Clock and guard timing around the shutdown pin release
  localparam int CLK_HZ = 10_000_000;
  localparam int GUARD_US = 10;
  localparam int GUARD_CYCLES = (GUARD_US * (CLK_HZ / 1_000_000) + 0) > 0 ?
                                GUARD_US * (CLK_HZ / 1_000_000) : 1;
  localparam logic [7:0] GUARD_LAST = 8'(GUARD_CYCLES - 1);

  // Device register map
  localparam logic [7:0] DUTY_FIRST = 8'h10;
  localparam logic [7:0] DUTY_LAST = 8'h56;
  localparam int DUTY_COUNT = 71;
  localparam logic [7:0] CONFIG_ADDR = 8'ha0;
  localparam int RUN_BIT = 0;
  localparam int MODE_BIT = 1;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // PWM step divider: one counter step every this many clocks
  localparam int PWM_DIV_CYCLES = 2;
  localparam logic [3:0] PWM_DIV_LAST = 4'(PWM_DIV_CYCLES - 1);

  // Host command register offsets
  localparam logic [3:0] HOST_CTRL = 4'h0;
  localparam logic [3:0] HOST_TARGET = 4'h1;
  localparam logic [3:0] HOST_WRITE = 4'h2;
  localparam logic [3:0] HOST_GAMMA = 4'h3;
  localparam logic [3:0] HOST_READ = 4'h4;
  localparam logic [3:0] HOST_RXDATA = 4'h5;
  localparam logic [3:0] HOST_STATUS = 4'h6;
  localparam int GAMMA_SEL_BIT = 7;
  localparam logic [5:0] GAMMA64_GIVEN = 6'd48;
  localparam logic [7:0] GAMMA64_TAIL = 8'hff;

  // Gamma curves, brightness index to duty value
  localparam logic [7:0] GAMMA32 [32] = '{
    8'd0, 8'd1, 8'd2, 8'd4, 8'd6, 8'd10, 8'd13, 8'd18,
    8'd22, 8'd28, 8'd33, 8'd39, 8'd46, 8'd53, 8'd61, 8'd69,
    8'd78, 8'd86, 8'd96, 8'd106, 8'd116, 8'd126, 8'd138, 8'd149,
    8'd161, 8'd173, 8'd186, 8'd199, 8'd212, 8'd226, 8'd240, 8'd255};
  localparam logic [7:0] GAMMA64 [48] = '{
    8'd0, 8'd1, 8'd2, 8'd3, 8'd4, 8'd5, 8'd6, 8'd7,
    8'd8, 8'd10, 8'd12, 8'd14, 8'd16, 8'd18, 8'd20, 8'd22,
    8'd24, 8'd26, 8'd29, 8'd32, 8'd35, 8'd38, 8'd41, 8'd44,
    8'd47, 8'd50, 8'd53, 8'd57, 8'd61, 8'd65, 8'd69, 8'd73,
    8'd77, 8'd81, 8'd85, 8'd89, 8'd94, 8'd99, 8'd104, 8'd109,
    8'd114, 8'd119, 8'd124, 8'd129, 8'd134, 8'd140, 8'd146, 8'd152};

  // Host sequencer states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_PTR = 3'b010,
    H_DATA = 3'b011,
    H_RD = 3'b100,
    H_RD_WAIT = 3'b101,
    H_PRE = 3'b110,
    H_POST = 3'b111
  } host_state_t;
endpackage : led_pwm_pkg

/* pkg/led_link_if.sv */
// Link between host sequencer and LED duty controller.
// Both ends share clk; all signals change right after a rising edge.
`timescale 1ns/1ps
interface led_link_if;
  logic shutdown_pin_n;
  logic start;
  logic byte_valid;
  logic [7:0] byte_data;
  logic read_req;
  logic [7:0] read_data;

  modport device (
    input shutdown_pin_n,
    input start,
    input byte_valid,
    input byte_data,
    input read_req,
    output read_data
  );

  modport host (
    output shutdown_pin_n,
    output start,
    output byte_valid,
    output byte_data,
    output read_req,
    input read_data
  );
endinterface : led_link_if

/* verilog/led_pwm_device.sv */
// LED matrix duty controller: register file, link front end, shutdown and PWM.
// Assumes the link signals are synchronous to clk and supply_good comes from a POR cell.
// Functional notes
// [R1] Hold everything reset until supply is good; the PWM divider, PWM counter and pin synchroniser keep running
// [R2] Shutdown pin low disables all output drive
// [R3] Registers stay accessible during hardware shutdown
// [R4] Shutdown pin rise resets link, leaves shutdown
// [R5] Host keeps link quiet around pin rise
// [R6] Average drive equals duty over 256
// [R7] Duty registers span offsets 0x10 to 0x56
// [R8] Host rewrites duty values for breathing effects
// [R9] Host maps intensity through a gamma curve
// [R10] 32-step gamma table values as given
// [R11] 64-step gamma table, first 48 values
// [R12] 32 steps for 1 s, 64 for 2 s
// [R13] Soft shutdown bit zero blanks the matrix
// [R14] Mode bit picks 8-bit or 6+2 duty
// [R15] Pin edge found from two successive samples
// [R16] Duty 0 dark, 255 lit 255 of 256
`timescale 1ns/1ps
module led_pwm_device (
  input wire logic clk,
  input wire logic nrst,
  input wire logic supply_good,
  led_link_if.device link,
  output logic [led_pwm_pkg::DUTY_COUNT-1:0] led_on,
  output logic sink_enable,
  output logic hw_shutdown
);
  import led_pwm_pkg::*;

  logic [7:0] duty_reg [DUTY_COUNT];
  logic [7:0] duty_next [DUTY_COUNT];
  logic [7:0] config_reg, config_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic phase_reg, phase_next;
  logic [2:0] pin_sync_reg, pin_sync_next;
  logic [3:0] div_reg, div_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [DUTY_COUNT-1:0] led_reg, led_next;
  logic drive_reg, drive_next;
  logic pin_rise;
  logic drive;
  logic [7:0] rd_idx;

  // Address falls in the duty window
  function automatic logic is_duty(input logic [7:0] a);
    is_duty = (a >= DUTY_FIRST) && (a <= DUTY_LAST); // [R7]
  endfunction : is_duty

  // One LED's on state for the current count and mode
  function automatic logic led_lit(input logic [7:0] d, input logic [7:0] c,
                                   input logic mode62);
    if (mode62) begin
      // Six-bit period repeated four times; low bits stretch some periods by one
      led_lit = (d[7:2] > c[5:0]) || ((d[7:2] == c[5:0]) && (c[7:6] < d[1:0])); // [R14]
    end else begin
      led_lit = d > c; // [R6] [R16]
    end
  endfunction : led_lit

  // Second sample against third; the first stage only feeds the second
  assign pin_rise = pin_sync_reg[1] & ~pin_sync_reg[2]; // [R15]
  // Pointer serves both writes and reads, so one index covers both
  assign rd_idx = ptr_reg - DUTY_FIRST;

  // Link front end and register file
  always_comb begin
    duty_next = duty_reg;
    config_next = config_reg;
    ptr_next = ptr_reg;
    phase_next = phase_reg;
    rdata_next = 8'h00;
    pin_sync_next = {pin_sync_reg[1:0], link.shutdown_pin_n};
    if (!supply_good) begin
      // Nothing initialises until the supply is up
      for (int i = 0; i < DUTY_COUNT; i++) begin
        duty_next[i] = DUTY_RESET; // [R1]
      end
      config_next = CONFIG_RESET; // [R1]
      ptr_next = PTR_RESET; // [R1]
      phase_next = 1'b0; // [R1]
    end else if (pin_rise) begin
      // Any half-done transfer from before the release is dropped
      ptr_next = PTR_RESET; // [R4]
      phase_next = 1'b0; // [R4]
    end else if (link.start) begin
      phase_next = 1'b0;
    end else if (link.byte_valid) begin
      // Access works whatever the shutdown state
      if (!phase_reg) begin
        ptr_next = link.byte_data;
        phase_next = 1'b1;
      end else begin
        if (is_duty(ptr_reg)) begin
          duty_next[rd_idx[6:0]] = link.byte_data; // [R3] [R7]
        end else if (ptr_reg == CONFIG_ADDR) begin
          config_next = link.byte_data; // [R3]
        end
        ptr_next = ptr_reg + 8'h01;
      end
    end else if (link.read_req) begin
      if (is_duty(ptr_reg)) begin
        rdata_next = duty_reg[rd_idx[6:0]]; // [R3] [R7]
      end else if (ptr_reg == CONFIG_ADDR) begin
        rdata_next = config_reg;
      end
      ptr_next = ptr_reg + 8'h01;
    end
  end

  // Register file and link state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DUTY_COUNT; i++) begin
        duty_reg[i] <= DUTY_RESET;
      end
      config_reg <= CONFIG_RESET;
      ptr_reg <= PTR_RESET;
      phase_reg <= 1'b0;
      rdata_reg <= 8'h00;
      pin_sync_reg <= 3'b000;
    end else begin
      duty_reg <= duty_next;
      config_reg <= config_next;
      ptr_reg <= ptr_next;
      phase_reg <= phase_next;
      rdata_reg <= rdata_next;
      pin_sync_reg <= pin_sync_next;
    end
  end

  // Drive allowed only with supply, pin high and soft shutdown bit set
  assign drive = supply_good & pin_sync_reg[1] & config_reg[RUN_BIT]; // [R1] [R2] [R13]

  // PWM counter and per-LED compare
  always_comb begin
    div_next = div_reg;
    cnt_next = cnt_reg;
    if (div_reg == PWM_DIV_LAST) begin
      div_next = 4'h0;
      cnt_next = cnt_reg + 8'h01; // 256 counts per period [R6]
    end else begin
      div_next = div_reg + 4'h1;
    end
    drive_next = drive;
    for (int i = 0; i < DUTY_COUNT; i++) begin
      led_next[i] = drive & led_lit(duty_reg[i], cnt_reg, config_reg[MODE_BIT]); // [R2] [R13]
    end
  end

  // PWM registers; led_on and sink_enable come straight from these
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 4'h0;
      cnt_reg <= 8'h00;
      led_reg <= '0;
      drive_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      led_reg <= led_next;
      drive_reg <= drive_next;
    end
  end

  assign led_on = led_reg;
  assign sink_enable = drive_reg;
  assign hw_shutdown = ~pin_sync_reg[1]; // [R2]
  assign link.read_data = rdata_reg;
endmodule : led_pwm_device

/* verilog/led_pwm_host.sv */
// Host sequencer: takes software orders over a plain register port and drives the link.
// Assumes the device samples the link on the same clk edge.
`timescale 1ns/1ps
module led_pwm_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [7:0] cmd_rdata,
  led_link_if.host link
);
  import led_pwm_pkg::*;

  host_state_t state_reg, state_next;
  logic [7:0] target_reg, target_next;
  logic [7:0] data_reg, data_next;
  logic [7:0] byte_reg, byte_next;
  logic [7:0] rx_reg, rx_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] guard_reg, guard_next;
  logic pin_reg, pin_next;
  logic idle;

  // Brightness index to duty value
  function automatic logic [7:0] gamma_of(input logic sel64, input logic [5:0] idx);
    if (sel64) begin
      // Two-second breathing; tail beyond the given entries is full scale
      gamma_of = (idx < GAMMA64_GIVEN) ? GAMMA64[idx] : GAMMA64_TAIL; // [R11] [R12]
    end else begin
      gamma_of = GAMMA32[idx[4:0]]; // [R10] [R12]
    end
  endfunction : gamma_of

  assign idle = (state_reg == H_IDLE);

  // Command decode and link sequencing
  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    data_next = data_reg;
    byte_next = byte_reg;
    rx_next = rx_reg;
    guard_next = guard_reg;
    pin_next = pin_reg;
    rdata_next = 8'h00;
    if (cmd_rd) begin
      unique case (cmd_addr)
        HOST_CTRL: rdata_next = {7'h00, pin_reg};
        HOST_TARGET: rdata_next = target_reg;
        HOST_RXDATA: rdata_next = rx_reg;
        HOST_STATUS: rdata_next = {6'h00, pin_reg, ~idle};
        default: rdata_next = 8'h00;
      endcase
    end
    unique case (state_reg)
      H_IDLE: begin
        // Write orders are ignored while busy; register reads are served in any state
        if (cmd_wr) begin
          unique case (cmd_addr)
            HOST_CTRL: begin
              if (!cmd_wdata[0]) begin
                pin_next = 1'b0;
              end else if (!pin_reg) begin
                guard_next = 8'h00;
                state_next = H_PRE; // [R5]
              end
            end
            HOST_TARGET: target_next = cmd_wdata;
            HOST_WRITE: begin
              data_next = cmd_wdata; // [R8]
              state_next = H_START;
            end
            HOST_GAMMA: begin
              data_next = gamma_of(cmd_wdata[GAMMA_SEL_BIT], cmd_wdata[5:0]); // [R9] [R8]
              state_next = H_START;
            end
            HOST_READ: begin
              data_next = 8'h00;
              state_next = H_START;
              rx_next = 8'h00;
            end
            default: state_next = H_IDLE;
          endcase
          if (cmd_addr == HOST_READ) begin
            guard_next = 8'h01;
          end else if (cmd_addr != HOST_CTRL) begin
            guard_next = 8'h00;
          end
        end
      end
      H_START: begin
        byte_next = target_reg;
        state_next = H_PTR;
      end
      H_PTR: begin
        byte_next = data_reg;
        state_next = (guard_reg == 8'h01) ? H_RD : H_DATA;
      end
      H_DATA: state_next = H_IDLE;
      H_RD: state_next = H_RD_WAIT;
      H_RD_WAIT: begin
        rx_next = link.read_data;
        state_next = H_IDLE;
      end
      H_PRE: begin
        // Link already quiet; count the guard before releasing the pin
        if (guard_reg == GUARD_LAST) begin
          guard_next = 8'h00;
          pin_next = 1'b1; // [R5]
          state_next = H_POST;
        end else begin
          guard_next = guard_reg + 8'h01;
        end
      end
      H_POST: begin
        // No transfer until the device has settled after the release
        if (guard_reg == GUARD_LAST) begin
          guard_next = 8'h00;
          state_next = H_IDLE; // [R5]
        end else begin
          guard_next = guard_reg + 8'h01;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= H_IDLE;
      target_reg <= 8'h00;
      data_reg <= 8'h00;
      byte_reg <= 8'h00;
      rx_reg <= 8'h00;
      rdata_reg <= 8'h00;
      guard_reg <= 8'h00;
      pin_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      target_reg <= target_next;
      data_reg <= data_next;
      byte_reg <= byte_next;
      rx_reg <= rx_next;
      rdata_reg <= rdata_next;
      guard_reg <= guard_next;
      pin_reg <= pin_next;
    end
  end

  assign cmd_rdata = rdata_reg;
  assign link.shutdown_pin_n = pin_reg;
  assign link.start = (state_reg == H_START);
  assign link.byte_valid = (state_reg == H_PTR) || (state_reg == H_DATA);
  assign link.byte_data = byte_reg;
  assign link.read_req = (state_reg == H_RD);
endmodule : led_pwm_host

/* tb/led_link_props.sv */
// Link checks between host sequencer and duty controller.
// Assumes one clk domain; instantiated beside the link interface.
`timescale 1ns/1ps
module led_link_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic supply_good,
  input wire logic shutdown_pin_n,
  input wire logic start,
  input wire logic byte_valid,
  input wire logic read_req,
  input wire logic [7:0] read_data,
  input wire logic [led_pwm_pkg::DUTY_COUNT-1:0] led_on,
  input wire logic sink_enable,
  input wire logic hw_shutdown
);
  import led_pwm_pkg::*;
  int quiet_cnt;
  int rise_cnt;
  logic pin_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Cycles since link traffic and since pin release, saturating at 1000
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quiet_cnt <= 0;
      rise_cnt <= 1000;
      pin_d <= 1'b0;
    end else begin
      pin_d <= shutdown_pin_n;
      quiet_cnt <= (start || byte_valid || read_req) ? 0 : quiet_cnt + int'(quiet_cnt < 1000);
      rise_cnt <= (shutdown_pin_n && !pin_d) ? 0 : rise_cnt + int'(rise_cnt < 1000);
    end
  end

  // Pin low is seen on the second sample
  a_fall_enter: assert property ($fell(shutdown_pin_n) |-> ##2 hw_shutdown)
    else $error("shutdown not entered after pin fall");
  a_shut_sink_off: assert property (hw_shutdown [*2] |-> !sink_enable)
    else $error("drive enabled in hardware shutdown");
  a_shut_leds_dark: assert property (hw_shutdown [*4] |-> led_on == '0)
    else $error("led lit in hardware shutdown");
  a_sink_leds_dark: assert property (!sink_enable [*3] |-> led_on == '0)
    else $error("led lit with drive off");
  a_supply_low_off: assert property (!supply_good |-> ##[1:2] !sink_enable)
    else $error("drive on with supply low");
  a_edge_two_samples: assert property (
    $rose(shutdown_pin_n) && supply_good |=> hw_shutdown ##1 !hw_shutdown)
    else $error("pin release not taken on second sample");
  a_read_idle_zero: assert property (!read_req |=> read_data == 8'h00)
    else $error("read data outside read cycle");
  // Guard time around release, both directions
  a_quiet_before: assert property ($rose(shutdown_pin_n) |-> quiet_cnt >= GUARD_CYCLES - 1)
    else $error("link traffic just before pin release");
  a_quiet_after: assert property (start |-> rise_cnt >= GUARD_CYCLES - 1)
    else $error("link traffic just after pin release");

  c_pin_release: cover property ($rose(shutdown_pin_n));
  c_led_lit: cover property (sink_enable && led_on != '0);
  c_read_back: cover property (read_req);
  c_supply_dip: cover property (!supply_good ##1 supply_good);
endmodule : led_link_props

/* tb/test_led_matrix_pwm_power_control.sv */
// Bench: software port drives host sequencer, which drives the duty controller.
// Assumes both ends share clk and meet through the link interface.
`timescale 1ns/1ps
module test_led_matrix_pwm_power_control;
  import led_pwm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic supply_good = 1'b0;
  logic [3:0] cmd_addr = 4'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic note_rd = 1'b0;
  logic chk_d = 1'b0;
  logic [7:0] cmd_rdata;
  logic [DUTY_COUNT-1:0] led_on;
  logic sink_enable;
  logic hw_shutdown;
  logic [7:0] exp_q[$];
  logic [7:0] rd_val;
  logic [7:0] d;
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 59542;
  int i;

  led_link_if led_link_if_inst ();
  led_pwm_device led_pwm_device_inst (.clk(clk), .nrst(nrst), .supply_good(supply_good),
    .link(led_link_if_inst), .led_on(led_on), .sink_enable(sink_enable),
    .hw_shutdown(hw_shutdown));
  led_pwm_host led_pwm_host_inst (.clk(clk), .nrst(nrst), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .link(led_link_if_inst));
  led_link_props led_link_props_inst (.clk(clk), .nrst(nrst), .supply_good(supply_good),
    .shutdown_pin_n(led_link_if_inst.shutdown_pin_n), .start(led_link_if_inst.start),
    .byte_valid(led_link_if_inst.byte_valid), .read_req(led_link_if_inst.read_req),
    .read_data(led_link_if_inst.read_data), .led_on(led_on), .sink_enable(sink_enable),
    .hw_shutdown(hw_shutdown));

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    cmd_addr <= a;
    cmd_wdata <= v;
    cmd_wr <= 1'b1;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask : bus_wr

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, input logic note);
    @(posedge clk);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    note_rd <= note;
    @(posedge clk);
    cmd_rd <= 1'b0;
    note_rd <= 1'b0;
    @(negedge clk);
    rd_val = cmd_rdata;
  endtask : bus_rd

  // Bounded poll; pin release alone takes some 200 cycles
  task automatic wait_idle();
    for (int k = 0; k < 400; k++) begin
      bus_rd(HOST_STATUS, 1'b0);
      if (rd_val[0] === 1'b0) return;
    end
    check(16'(rd_val[0]), 16'h0);
  endtask : wait_idle

  task automatic dev_wr(input logic [7:0] ra, input logic [7:0] v, input logic [3:0] op);
    bus_wr(HOST_TARGET, ra);
    bus_wr(op, v);
    wait_idle();
  endtask : dev_wr

  task automatic dev_rd(input logic [7:0] ra, input logic [7:0] e);
    dev_wr(ra, 8'h00, HOST_READ);
    exp_q.push_back(e);
    bus_rd(HOST_RXDATA, 1'b1);
  endtask : dev_rd

  // One full PWM period is 256 steps of 2 clocks
  task automatic measure(input logic [7:0] dv);
    logic [15:0] n0, n1, n2;
    n0 = 0;
    n1 = 0;
    n2 = 0;
    repeat (512) begin
      @(negedge clk);
      n0 = n0 + led_on[0];
      n1 = n1 + led_on[1];
      n2 = n2 + led_on[2];
    end
    check(n0, 16'd0);
    check(n1, 16'd510);
    check(n2, 16'(dv) * 16'd2);
  endtask : measure

  // Compare each noted read in the cycle its data stands
  always @(posedge clk) begin
    if (chk_d) begin
      check(16'(cmd_rdata), 16'(exp_q.pop_front()));
    end
    chk_d <= cmd_rd && note_rd;
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    supply_good <= 1'b1;
    @(negedge clk);
    check(16'(hw_shutdown), 16'h1);
    check(16'(sink_enable), 16'h0);
    // Map edges and an unmapped place, pin still low
    dev_wr(DUTY_FIRST, 8'h5a, HOST_WRITE);
    dev_wr(DUTY_LAST, 8'ha5, HOST_WRITE);
    dev_wr(8'h57, 8'h33, HOST_WRITE);
    dev_rd(DUTY_FIRST, 8'h5a);
    dev_rd(DUTY_LAST, 8'ha5);
    dev_rd(8'h57, 8'h00);
    // Every gamma index of both curves
    for (i = 0; i < 96; i++) begin
      dev_wr(DUTY_FIRST + 8'(i % 64), {i >= 32, 1'b0, 6'(i < 32 ? i : i - 32)},
        HOST_GAMMA);
      dev_rd(DUTY_FIRST + 8'(i % 64), i < 32 ? GAMMA32[i] :
        (i < 80 ? GAMMA64[i - 32] : GAMMA64_TAIL));
    end
    bus_wr(HOST_CTRL, 8'h01);
    wait_idle();
    check(16'(hw_shutdown), 16'h0);
    check(16'(sink_enable), 16'h0);
    // Status shows pin high and sequencer idle
    exp_q.push_back(8'h02);
    bus_rd(HOST_STATUS, 1'b1);
    dev_wr(CONFIG_ADDR, 8'h01, HOST_WRITE);
    check(16'(sink_enable), 16'h1);
    d = 8'($random(seed));
    dev_wr(DUTY_FIRST, 8'h00, HOST_WRITE);
    dev_wr(DUTY_FIRST + 8'h01, 8'hff, HOST_WRITE);
    dev_wr(DUTY_FIRST + 8'h02, d, HOST_WRITE);
    measure(d);
    // Same averages expected in the 6+2 mode
    dev_wr(CONFIG_ADDR, 8'h03, HOST_WRITE);
    dev_rd(CONFIG_ADDR, 8'h03);
    measure(d);
    bus_wr(HOST_CTRL, 8'h00);
    wait_idle();
    repeat (4) @(negedge clk);
    check(16'(hw_shutdown), 16'h1);
    check(16'(|led_on), 16'h0);
    dev_rd(DUTY_FIRST + 8'h01, 8'hff);
    // Supply dip with pin high; settle before more traffic
    bus_wr(HOST_CTRL, 8'h01);
    wait_idle();
    supply_good <= 1'b0;
    repeat (3) @(posedge clk);
    supply_good <= 1'b1;
    repeat (10) @(posedge clk);
    dev_rd(DUTY_FIRST + 8'h01, DUTY_RESET);
    dev_rd(CONFIG_ADDR, CONFIG_RESET);
    check(16'(sink_enable), 16'h0);
    final_report();
  end

  // Watchdog: the run needs some 3.5k cycles
  initial begin
    #(40_000 * 100);
    error_cnt++;
    final_report();
  end
endmodule : test_led_matrix_pwm_power_control
